/* core/lbs_seq.sv */
/*
  start-up, shutdown and open-string fault sequencer for an led boost stage.
  assumes comparator inputs and the control pin are synchronous to core_clk;
  the analogue loop consumes ref_code, half_limit and the switch gate.
*/
module lbs_seq #(
  parameter int STEP_CYC = lbs_pkg::STEP_CYC,
  parameter int HALF_LIM_CYC = lbs_pkg::HALF_LIM_CYC,
  parameter int SHDN_CYC = lbs_pkg::SHDN_CYC,
  parameter int FAULT_QUAL = lbs_pkg::FAULT_QUAL_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic ctrl_in,
  input wire logic switch_node_ovp,
  input wire logic sense_feedback_low,
  input wire logic [7:0] loop_duty,
  output logic switch_gate,
  output logic [4:0] ref_code,
  output logic [4:0] brightness,
  output logic half_limit,
  output logic shutdown,
  output logic open_fault
);
  // switch_node_ovp: comparator above the 38 V threshold
  logic rst_meta;
  logic rst_n;
  lbs_pkg::lbs_state_t state;
  logic [22:0] low_cnt;
  logic [22:0] step_cnt;
  logic [22:0] half_cnt;
  logic [5:0] step_idx;
  logic [3:0] qual_cnt;
  logic ctrl_seen_low;
  logic gate_w;
  logic tick;
  logic shdn_req;
  logic fault_hit;
  logic run;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  assign run = (state == lbs_pkg::LBS_RAMP) || (state == lbs_pkg::LBS_RUN);
  // dimming decode lives elsewhere; here the pin only acts as enable
  assign shdn_req = !ctrl_in && (low_cnt >= 23'(SHDN_CYC));
  assign fault_hit = tick && switch_node_ovp && sense_feedback_low
    && (qual_cnt == 4'(FAULT_QUAL - 1));

  lbs_pwm #(.PERIOD(lbs_pkg::SW_PERIOD_CYC)) u_pwm (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .en(run && !fault_hit && !shdn_req),
    .duty(loop_duty),
    .gate(gate_w),
    .cycle_tick(tick)
  );

  // low-time filter: counts while low, saturates at the limit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= '0;
    end else if (clk_en) begin
      if (ctrl_in) begin
        low_cnt <= '0;
      end else if (low_cnt < 23'(SHDN_CYC)) begin
        low_cnt <= low_cnt + 1'b1;
      end
    end
  end

  // a fault needs a fresh low level on the pin before high re-enables
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_seen_low <= 1'b0;
    end else if (clk_en) begin
      if (state != lbs_pkg::LBS_FAULT) begin
        ctrl_seen_low <= 1'b0;
      end else if (!ctrl_in) begin
        ctrl_seen_low <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= lbs_pkg::LBS_SHDN;
    end else if (clk_en) begin
      case (state)
        lbs_pkg::LBS_SHDN: begin
          if (ctrl_in) state <= lbs_pkg::LBS_RAMP;
        end
        lbs_pkg::LBS_RAMP, lbs_pkg::LBS_RUN: begin
          if (fault_hit) begin
            state <= lbs_pkg::LBS_FAULT;
          end else if (shdn_req) begin
            state <= lbs_pkg::LBS_SHDN;
          end else if (state == lbs_pkg::LBS_RAMP
                       && step_idx == 6'(lbs_pkg::RAMP_STEPS)) begin
            state <= lbs_pkg::LBS_RUN;
          end
        end
        lbs_pkg::LBS_FAULT: begin
          if (ctrl_seen_low && ctrl_in) state <= lbs_pkg::LBS_RAMP;
        end
        default: state <= lbs_pkg::LBS_SHDN;
      endcase
    end
  end

  // ramp: step_idx counts completed 213 us steps
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt <= '0;
      step_idx <= '0;
    end else if (clk_en) begin
      if (!run) begin
        step_cnt <= '0;
        step_idx <= '0;
      end else if (step_idx < 6'(lbs_pkg::RAMP_STEPS)) begin
        if (step_cnt == 23'(STEP_CYC - 1)) begin
          step_cnt <= '0;
          step_idx <= step_idx + 1'b1;
        end else begin
          step_cnt <= step_cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt <= '0;
      half_limit <= 1'b1;
    end else if (clk_en) begin
      if (!run) begin
        half_cnt <= '0;
        half_limit <= 1'b1;
      end else if (half_cnt < 23'(HALF_LIM_CYC)) begin
        half_cnt <= half_cnt + 1'b1;
        half_limit <= 1'b1;
      end else begin
        half_limit <= 1'b0;
      end
    end
  end

  // consecutive qualifying switching cycles only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      qual_cnt <= '0;
    end else if (clk_en) begin
      if (!run) begin
        qual_cnt <= '0;
      end else if (tick) begin
        if (switch_node_ovp && sense_feedback_low) begin
          qual_cnt <= fault_hit ? '0 : qual_cnt + 1'b1;
        end else begin
          qual_cnt <= '0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      brightness <= lbs_pkg::REF_FULL;
      ref_code <= lbs_pkg::REF_ZERO;
    end else if (clk_en) begin
      if (!run) begin
        brightness <= lbs_pkg::REF_FULL;
        ref_code <= lbs_pkg::REF_ZERO;
      end else if (step_idx >= 6'(lbs_pkg::RAMP_STEPS)) begin
        ref_code <= brightness;
      end else begin
        ref_code <= step_idx[4:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      switch_gate <= 1'b0;
      shutdown <= 1'b1;
      open_fault <= 1'b0;
    end else if (clk_en) begin
      switch_gate <= gate_w && run;
      shutdown <= !run;
      open_fault <= (state == lbs_pkg::LBS_FAULT);
    end
  end

  property p_fault_off;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && (state == lbs_pkg::LBS_FAULT) |=> !switch_gate;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("switch gated while faulted");

  property p_qual_reset;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && run && tick && !switch_node_ovp |=> qual_cnt == 4'h0;
  endproperty
  a_qual_reset: assert property (p_qual_reset)
    else $error("fault count not cleared");

  sequence s_fault_qual;
    clk_en && fault_hit;
  endsequence

  // flags trail the state by one enabled edge
  sequence s_fault_shown;
    state == lbs_pkg::LBS_FAULT ##1 (open_fault || !$past(clk_en));
  endsequence

  property p_fault_enter;
    @(posedge core_clk) disable iff (!rst_n)
    s_fault_qual |=> s_fault_shown;
  endproperty
  a_fault_enter: assert property (p_fault_enter)
    else $error("fault not latched");

  property p_fault_hold;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && state == lbs_pkg::LBS_FAULT && !ctrl_seen_low
      |=> state == lbs_pkg::LBS_FAULT;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault left without toggle");

  property p_shdn_enter;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && state == lbs_pkg::LBS_RUN && shdn_req && !fault_hit
      |=> state == lbs_pkg::LBS_SHDN;
  endproperty
  a_shdn_enter: assert property (p_shdn_enter)
    else $error("shutdown missed");

  property p_ramp_start;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && state == lbs_pkg::LBS_SHDN && ctrl_in
      |=> state == lbs_pkg::LBS_RAMP;
  endproperty
  a_ramp_start: assert property (p_ramp_start)
    else $error("enable ignored");

  property p_full_ref;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && state == lbs_pkg::LBS_RUN |=> ref_code == lbs_pkg::REF_FULL
      || !clk_en || state != lbs_pkg::LBS_RUN;
  endproperty
  a_full_ref: assert property (p_full_ref)
    else $error("reference not full scale");

  property p_shdn_clear;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && !run |=> step_idx == 6'h00 && half_limit;
  endproperty
  a_shdn_clear: assert property (p_shdn_clear)
    else $error("start-up timers not reset");
endmodule : lbs_seq

/* core/lbs_pkg.sv */
/*
  shared constants for the led boost start-up and fault sequencer.
  assumes a 50 MHz core clock; all times are turned into cycle counts here.
*/
package lbs_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int SW_HZ = 600_000;
  // switching period, rounded down so the rate is never below nominal
  localparam int SW_PERIOD_CYC = CLK_HZ / SW_HZ;
  localparam int RAMP_STEPS = 32;
  localparam int STEP_TIME_NS = 213_000;
  localparam int STEP_CYC = (STEP_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int HALF_LIM_TIME_US = 5_000;
  localparam int HALF_LIM_CYC = HALF_LIM_TIME_US * (CLK_HZ / 1_000_000);
  localparam int SHDN_TIME_US = 2_500;
  localparam int SHDN_CYC = SHDN_TIME_US * (CLK_HZ / 1_000_000);
  localparam int FAULT_QUAL_CYCLES = 8;
  localparam int OVP_THRESH_MV = 38_000;
  localparam int VREF_MV = 200;
  localparam int REF_W = 5;
  localparam logic [4:0] REF_FULL = 5'h1F;
  localparam logic [4:0] REF_ZERO = 5'h00;
  localparam logic [7:0] DUTY_ZERO = 8'h00;
  typedef enum logic [3:0] {
    LBS_SHDN  = 4'b0001,
    LBS_RAMP  = 4'b0010,
    LBS_RUN   = 4'b0100,
    LBS_FAULT = 4'b1000
  } lbs_state_t;
endpackage : lbs_pkg

/* core/lbs_pwm.sv */
/*
  fixed-rate pwm gate generator for the power switch.
  assumes duty is a fraction of 256 of the period; en low forces gate off.
*/
module lbs_pwm #(
  parameter int PERIOD = lbs_pkg::SW_PERIOD_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic en,
  input wire logic [7:0] duty,
  output logic gate,
  output logic cycle_tick
);
  localparam int CW = $clog2(PERIOD);
  logic [CW-1:0] cnt;
  logic [15:0] on_cyc;

  assign on_cyc = 16'(duty) * 16'(PERIOD) >> 8;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      cycle_tick <= 1'b0;
    end else if (clk_en) begin
      cycle_tick <= (cnt == CW'(PERIOD - 1));
      cnt <= (cnt == CW'(PERIOD - 1)) ? '0 : cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate <= 1'b0;
    end else if (clk_en) begin
      gate <= en && (16'(cnt) < on_cyc);
    end
  end
endmodule : lbs_pwm

/* verification/lbs_stage_model.sv */
/*
  behavioural boost power stage facing the sequencer's comparator inputs.
  assumes the bench chooses when the led string is open.
*/
module lbs_stage_model (
  input wire logic core_clk,
  input wire logic switch_gate,
  input wire logic open_string,
  output logic switch_node_ovp,
  output logic sense_feedback_low,
  output logic [7:0] loop_duty
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pumped;
  // node only climbs past the limit once the switch has pulsed
  always_ff @(posedge core_clk) begin
    if (!open_string) pumped <= 1'b0;
    else if (switch_gate) pumped <= 1'b1;
  end
  assign switch_node_ovp = pumped;
  assign sense_feedback_low = open_string;
  assign loop_duty = 8'h80;
endmodule : lbs_stage_model

/* verification/led_boost_startup_fault_sequencer_tb.sv */
/*
  self-checking bench for the led boost start-up and fault sequencer.
  assumes lbs_seq with shortened timers and the stage model as far side.
*/
module led_boost_startup_fault_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 8;
  localparam int HALF = 40;
  localparam int SHDN = 30;
  localparam int PER = lbs_pkg::SW_PERIOD_CYC;
  logic core_clk, resetn, ctrl_in, open_string, clk_en;
  logic switch_node_ovp, sense_feedback_low, switch_gate, half_limit;
  logic shutdown, open_fault;
  logic [7:0] loop_duty;
  logic [4:0] ref_code, brightness;
  int mismatches, checks;

  lbs_seq #(.STEP_CYC(STEP), .HALF_LIM_CYC(HALF), .SHDN_CYC(SHDN)) u_dut (
    .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .ctrl_in(ctrl_in), .switch_node_ovp(switch_node_ovp),
    .sense_feedback_low(sense_feedback_low), .loop_duty(loop_duty),
    .switch_gate(switch_gate), .ref_code(ref_code),
    .brightness(brightness), .half_limit(half_limit),
    .shutdown(shutdown), .open_fault(open_fault));
  lbs_stage_model u_stage (
    .core_clk(core_clk), .switch_gate(switch_gate),
    .open_string(open_string), .switch_node_ovp(switch_node_ovp),
    .sense_feedback_low(sense_feedback_low), .loop_duty(loop_duty));

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // samples at the falling edge, well clear of the launching edge
  task automatic cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic drive(logic c, logic o);
    @(posedge core_clk);
    ctrl_in <= c;
    open_string <= o;
  endtask : drive
  task automatic wait_shdn(logic v, int lim, output int n);
    n = 0;
    while (shutdown !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wait_shdn
  task automatic gate_edges(int n, output int e);
    logic prev;
    e = 0;
    prev = switch_gate;
    repeat (n) begin
      cyc(1);
      if (switch_gate === 1'b1 && prev === 1'b0) e++;
      prev = switch_gate;
    end
  endtask : gate_edges

  task automatic start_up;
    logic [4:0] prev;
    int n, gap, steps, hi;
    drive(1'b1, 1'b0);
    wait_shdn(1'b0, 10, n);
    check("leave_shdn", shutdown, 0);
    check("ref_start", ref_code, 0);
    check("brightness", brightness, 5'h1F);
    check("half_start", half_limit, 1);
    prev = ref_code;
    gap = -1;
    steps = 0;
    hi = 1;
    repeat (40 * STEP) begin
      cyc(1);
      if (half_limit === 1'b1) hi++;
      if (gap >= 0) gap++;
      if (ref_code !== prev) begin
        check("ref_step", ref_code, prev + 5'd1);
        if (gap >= 0) check("step_time", gap, STEP);
        gap = 0;
        prev = ref_code;
        steps++;
      end
    end
    check("steps", steps, 31);
    check("ref_final", ref_code, 5'h1F);
    check("half_end", half_limit, 0);
    check("half_time", hi, HALF);
    gate_edges(4 * PER, n);
    check("gate_rate", n, 4);
  endtask : start_up

  task automatic ctrl_low_time;
    int n;
    drive(1'b0, 1'b0);
    cyc(SHDN - 10);
    drive(1'b1, 1'b0);
    cyc(20);
    check("short_low", shutdown, 0);
    drive(1'b0, 1'b0);
    wait_shdn(1'b1, SHDN + 10, n);
    check("long_low", shutdown, 1);
    check("low_time", n >= SHDN, 1);
    gate_edges(3 * PER, n);
    check("shdn_gate", n, 0);
  endtask : ctrl_low_time

  task automatic fault_latch;
    int n;
    drive(1'b1, 1'b1);
    n = 0;
    while (open_fault !== 1'b1 && n < 12 * PER) begin
      cyc(1);
      n++;
    end
    check("fault_set", open_fault, 1);
    check("fault_late", n >= 7 * PER, 1);
    check("fault_shdn", shutdown, 1);
    gate_edges(3 * PER, n);
    check("fault_gate", n, 0);
    drive(1'b1, 1'b0);
    cyc(3 * PER);
    check("latched", open_fault, 1);
    drive(1'b0, 1'b0);
    drive(1'b1, 1'b0);
    wait_shdn(1'b0, 20, n);
    check("rearm_fault", open_fault, 0);
    check("rearm_shdn", shutdown, 0);
  endtask : fault_latch

  // broken run of qualifying cycles must not add up to a fault
  task automatic intermittent;
    drive(1'b1, 1'b1);
    cyc(5 * PER);
    drive(1'b1, 1'b0);
    cyc(2 * PER);
    drive(1'b1, 1'b1);
    cyc(5 * PER);
    check("no_fault", open_fault, 0);
    drive(1'b1, 1'b0);
  endtask : intermittent

  // enable low must hold every state, the low-time filter included
  task automatic freeze;
    int n;
    @(posedge core_clk);
    clk_en <= 1'b0;
    ctrl_in <= 1'b0;
    cyc(SHDN + 10);
    check("frz_shdn", shutdown, 0);
    check("frz_ref", ref_code, 5'h1F);
    gate_edges(2 * PER, n);
    check("frz_gate", n, 0);
    @(posedge core_clk);
    clk_en <= 1'b1;
    ctrl_in <= 1'b1;
    cyc(SHDN + 10);
    check("frz_run", shutdown, 0);
  endtask : freeze

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    mismatches = 0;
    checks = 0;
    resetn = 1'b0;
    clk_en = 1'b1;
    ctrl_in = 1'b0;
    open_string = 1'b0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    cyc(4);
    check("reset_shdn", shutdown, 1);
    check("reset_fault", open_fault, 0);
    start_up();
    ctrl_low_time();
    start_up();
    fault_latch();
    intermittent();
    freeze();
    end_of_test();
  end
  initial begin
    #(50_000 * 20);
    mismatches++;
    end_of_test();
  end
endmodule : led_boost_startup_fault_sequencer_tb
